// [block_transfer_engine.sv]
// block transfer engine: moves pixel windows into display memory
// assumes all inputs come from logic on CLK; memory answers read data
// with MEM_RVALID at least one cycle after MEM_GNT
// What this block does
// - thirteen operations run alone once started
// - codes 0 and 2: raster host, copy
// - codes 4, 5, 7 chroma keyed, no raster
// - code 6 pattern fill through raster function
// - codes 8, 9, E, F colour expansion
// - codes A, B blend; C solid fill
// - raster high nibble: constants, copies, inversions
// - other raster codes are bitwise combinations
// - source zero host or memory, rest memory
// - raster field gives expansion start bit
// - stays busy until the whole window done
// - busy shown in control zero and status
// - completion raises active-low interrupt and source
// - keyed pixel equal to background is skipped
// - expansion bit one foreground, zero background
`timescale 1ns/10ps
`default_nettype none

module block_transfer_engine
   import bte_pkg::*;
#(
   parameter int ADDR_W     = 24,
   parameter int COORD_W    = 13,
   parameter int HOST_BUS_W = 16,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input  wire logic               CLK,
   input  wire logic               RST,
   input  wire logic [7:0]         REG_ADDR,
   input  wire logic [7:0]         REG_WDATA,
   input  wire logic               REG_WE,
   input  wire logic               REG_RE,
   output logic      [7:0]         REG_RDATA,
   output logic      [7:0]         STATUS,
   input  wire logic               INT_EN,
   output logic                    INT_N,
   input  wire logic [ADDR_W-1:0]  S0_BASE,
   input  wire logic [ADDR_W-1:0]  S1_BASE,
   input  wire logic [ADDR_W-1:0]  DT_BASE,
   input  wire logic [COORD_W-1:0] STRIDE,
   input  wire logic [COORD_W-1:0] WIN_W,
   input  wire logic [COORD_W-1:0] WIN_H,
   input  wire logic [PIX_W-1:0]   FG_COLOR,
   input  wire logic [PIX_W-1:0]   BG_COLOR,
   input  wire logic [5:0]         ALPHA,
   input  wire logic               PATTERN_16,
   input  wire logic [PIX_W-1:0]   HOST_DATA,
   input  wire logic               HOST_VALID,
   output logic                    HOST_READY,
   output logic                    MEM_REQ,
   output logic                    MEM_WE,
   output logic      [ADDR_W-1:0]  MEM_ADDR,
   output logic      [PIX_W-1:0]   MEM_WDATA,
   input  wire logic               MEM_GNT,
   input  wire logic               MEM_RVALID,
   input  wire logic [PIX_W-1:0]   MEM_RDATA
);

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_SRC  = 8'h02,
      ST_RD0  = 8'h04,
      ST_WT0  = 8'h08,
      ST_RD1  = 8'h10,
      ST_WT1  = 8'h20,
      ST_CALC = 8'h40,
      ST_WR   = 8'h80
   } state_e;

   typedef struct packed {
      state_e             state;
      logic               busy;
      logic               int_flag;
      logic [7:0]         ctrl1;
      logic [7:0]         rdata;
      logic [COORD_W-1:0] x;
      logic [COORD_W-1:0] y;
      logic [ADDR_W-1:0]  s0_row;
      logic [ADDR_W-1:0]  s1_row;
      logic [ADDR_W-1:0]  dt_row;
      logic [PIX_W-1:0]   s0;
      logic [PIX_W-1:0]   s1;
      logic [PIX_W-1:0]   word;
      logic [3:0]         bit_idx;
      logic               have_word;
      logic               skip;
      logic               mem_req;
      logic               mem_we;
      logic [ADDR_W-1:0]  mem_addr;
      logic [PIX_W-1:0]   mem_wdata;
   } engine_s;

   engine_s          r;
   engine_s          next_r;
   logic [3:0]       op;
   logic [3:0]       rop_code;
   logic             host_src;
   logic             pattern;
   logic             expand;
   logic             key;
   logic             exp_transp;
   logic             blend;
   logic             rop_used;
   logic             solid;
   logic             needs_s1;
   logic             op_valid;
   logic             start_req;
   logic             last_x;
   logic             last_y;
   logic             step;
   logic             fifo_pop;
   logic             fifo_valid;
   logic [PIX_W-1:0] fifo_data;
   logic [PIX_W-1:0] rop_out;
   logic [3:0]       exp_top;
   logic [3:0]       exp_start;
   logic [ADDR_W-1:0] s0_addr;
   logic [ADDR_W-1:0] pat_index;

   function automatic logic [PIX_W-1:0] blend565(input logic [PIX_W-1:0] a,
                                                 input logic [PIX_W-1:0] b,
                                                 input logic [5:0] al);
      logic [5:0]  ac;
      logic [5:0]  bc;
      logic [11:0] rr;
      logic [11:0] gg;
      logic [11:0] bb;
      // levels above full opacity are clamped rather than wrapped
      ac = (al > ALPHA_FULL) ? ALPHA_FULL : al;
      bc = ALPHA_FULL - ac;
      rr = 12'(a[15:11]) * 12'(ac) + 12'(b[15:11]) * 12'(bc);
      gg = 12'(a[10:5]) * 12'(ac) + 12'(b[10:5]) * 12'(bc);
      bb = 12'(a[4:0]) * 12'(ac) + 12'(b[4:0]) * 12'(bc);
      return {rr[9:5], gg[10:5], bb[9:5]};
   endfunction

   pixel_word_fifo #(
      .WIDTH (PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) host_fifo (
      .clk       (CLK),
      .rst       (RST),
      .in_data   (HOST_DATA),
      .in_valid  (HOST_VALID),
      .in_ready  (HOST_READY),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   assign op = r.ctrl1[3:0];
   assign rop_code = r.ctrl1[7:ROP_LSB];

   // truth table lookup: the code itself is the function of the two bits
   for (genvar i = 0; i < PIX_W; i++) begin : g_rop
      assign rop_out[i] = rop_code[{r.s0[i], r.s1[i]}];
   end

   always_comb begin
      host_src   = (op == OP_HOST_ROP) || (op == OP_HOST_KEY) || (op == OP_HOST_EXP) ||
                   (op == OP_HOST_EXP_KEY) || (op == OP_HOST_BLEND);
      pattern    = (op == OP_PAT_ROP) || (op == OP_PAT_KEY);
      expand     = (op == OP_HOST_EXP) || (op == OP_HOST_EXP_KEY) ||
                   (op == OP_MEM_EXP) || (op == OP_MEM_EXP_KEY);
      exp_transp = (op == OP_HOST_EXP_KEY) || (op == OP_MEM_EXP_KEY);
      key        = (op == OP_HOST_KEY) || (op == OP_MEM_KEY) || (op == OP_PAT_KEY);
      blend      = (op == OP_MEM_BLEND) || (op == OP_HOST_BLEND);
      rop_used   = (op == OP_HOST_ROP) || (op == OP_MEM_ROP) || (op == OP_PAT_ROP);
      solid      = (op == OP_SOLID);
      needs_s1   = rop_used || blend;
      // reserved codes never start, so their behaviour stays harmless
      op_valid   = rop_used || pattern || expand || key || blend || solid;
   end

   always_comb begin
      exp_top   = host_src ? 4'(HOST_BUS_W - 1) : 4'(MEM_PIX_BITS - 1);
      // a narrow host bus only has the low start positions
      exp_start = (host_src && HOST_BUS_W == 8) ? {1'b0, rop_code[2:0]} : rop_code;
      pat_index = PATTERN_16 ? ADDR_W'({r.y[3:0], r.x[3:0]}) :
                               ADDR_W'({r.y[2:0], r.x[2:0]});
      s0_addr   = pattern ? (S0_BASE + pat_index) : (r.s0_row + ADDR_W'(r.x));
      last_x    = (r.x == WIN_W - 1'b1);
      last_y    = (r.y == WIN_H - 1'b1);
      start_req = REG_WE && (REG_ADDR == CTRL0_OFFSET) && REG_WDATA[CTRL0_BUSY_BIT];
   end

   always_comb begin
      next_r = r;
      step = 1'b0;
      fifo_pop = 1'b0;
      if (REG_RE) begin
         next_r.rdata = '0;
         unique case (REG_ADDR)
            CTRL0_OFFSET:  next_r.rdata[CTRL0_BUSY_BIT] = r.busy;
            CTRL1_OFFSET:  next_r.rdata = r.ctrl1;
            INTSRC_OFFSET: next_r.rdata[INTSRC_ENGINE_BIT] = r.int_flag;
            default:       next_r.rdata = '0;
         endcase
      end
      // control one is frozen for the whole operation
      if (REG_WE && REG_ADDR == CTRL1_OFFSET && !r.busy) begin
         next_r.ctrl1 = REG_WDATA;
      end
      if (REG_WE && REG_ADDR == INTSRC_OFFSET && REG_WDATA[INTSRC_ENGINE_BIT]) begin
         next_r.int_flag = 1'b0;
      end
      unique case (r.state)
         ST_IDLE: begin
            if (start_req && op_valid && WIN_W != '0 && WIN_H != '0) begin
               next_r.busy = 1'b1;
               next_r.x = '0;
               next_r.y = '0;
               next_r.s0_row = S0_BASE;
               next_r.s1_row = S1_BASE;
               next_r.dt_row = DT_BASE;
               next_r.have_word = 1'b0;
               next_r.state = ST_SRC;
            end
         end
         ST_SRC: begin
            next_r.skip = 1'b0;
            if (solid) begin
               next_r.s0 = FG_COLOR;
               next_r.state = ST_CALC;
            end else if (expand && r.have_word) begin
               next_r.s0 = r.word[r.bit_idx] ? FG_COLOR : BG_COLOR;
               next_r.skip = exp_transp && !r.word[r.bit_idx];
               next_r.bit_idx = r.bit_idx + 1'b1;
               if (r.bit_idx == exp_top) begin
                  next_r.have_word = 1'b0;
               end
               next_r.state = ST_CALC;
            end else if (host_src) begin
               if (fifo_valid) begin
                  fifo_pop = 1'b1;
                  if (expand) begin
                     next_r.word = fifo_data;
                     next_r.have_word = 1'b1;
                     next_r.bit_idx = exp_start;
                  end else begin
                     next_r.s0 = fifo_data;
                     if (needs_s1) begin
                        next_r.mem_req = 1'b1;
                        next_r.mem_addr = r.s1_row + ADDR_W'(r.x);
                        next_r.state = ST_RD1;
                     end else begin
                        next_r.state = ST_CALC;
                     end
                  end
               end
            end else begin
               next_r.mem_req = 1'b1;
               next_r.mem_we = 1'b0;
               next_r.mem_addr = s0_addr;
               next_r.state = ST_RD0;
            end
         end
         ST_RD0: begin
            if (MEM_GNT) begin
               next_r.mem_req = 1'b0;
               next_r.state = ST_WT0;
            end
         end
         ST_WT0: begin
            if (MEM_RVALID) begin
               if (expand) begin
                  next_r.word = MEM_RDATA;
                  next_r.have_word = 1'b1;
                  next_r.bit_idx = exp_start;
                  next_r.state = ST_SRC;
               end else begin
                  next_r.s0 = MEM_RDATA;
                  if (needs_s1) begin
                     next_r.mem_req = 1'b1;
                     next_r.mem_addr = r.s1_row + ADDR_W'(r.x);
                     next_r.state = ST_RD1;
                  end else begin
                     next_r.state = ST_CALC;
                  end
               end
            end
         end
         ST_RD1: begin
            if (MEM_GNT) begin
               next_r.mem_req = 1'b0;
               next_r.state = ST_WT1;
            end
         end
         ST_WT1: begin
            if (MEM_RVALID) begin
               next_r.s1 = MEM_RDATA;
               next_r.state = ST_CALC;
            end
         end
         ST_CALC: begin
            if (r.skip || (key && r.s0 == BG_COLOR)) begin
               step = 1'b1;
            end else begin
               next_r.mem_req = 1'b1;
               next_r.mem_we = 1'b1;
               next_r.mem_addr = r.dt_row + ADDR_W'(r.x);
               if (rop_used) begin
                  next_r.mem_wdata = rop_out;
               end else if (blend) begin
                  next_r.mem_wdata = blend565(r.s0, r.s1, ALPHA);
               end else begin
                  next_r.mem_wdata = r.s0;
               end
               next_r.state = ST_WR;
            end
         end
         ST_WR: begin
            if (MEM_GNT) begin
               next_r.mem_req = 1'b0;
               next_r.mem_we = 1'b0;
               step = 1'b1;
            end
         end
      endcase
      if (step) begin
         next_r.state = ST_SRC;
         if (last_x) begin
            next_r.x = '0;
            // each row starts a fresh source word
            next_r.have_word = 1'b0;
            if (last_y) begin
               next_r.busy = 1'b0;
               next_r.int_flag = 1'b1;
               next_r.state = ST_IDLE;
            end else begin
               next_r.y = r.y + 1'b1;
               next_r.s0_row = r.s0_row + ADDR_W'(STRIDE);
               next_r.s1_row = r.s1_row + ADDR_W'(STRIDE);
               next_r.dt_row = r.dt_row + ADDR_W'(STRIDE);
            end
         end else begin
            next_r.x = r.x + 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r <= '{state: ST_IDLE, ctrl1: CTRL1_RESET, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign REG_RDATA = r.rdata;
   assign STATUS = 8'(r.busy) << STATUS_BUSY_BIT;
   assign INT_N = !(r.int_flag && INT_EN);
   assign MEM_REQ = r.mem_req;
   assign MEM_WE = r.mem_we;
   assign MEM_ADDR = r.mem_addr;
   assign MEM_WDATA = r.mem_wdata;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   busy_flag_a: assert property (STATUS[STATUS_BUSY_BIT] == (r.state != ST_IDLE))
      else $error("status busy bit disagrees with engine state");
   start_idle_a: assert property ($rose(r.busy) |-> $past(r.state) == ST_IDLE)
      else $error("busy rose outside idle");
   busy_end_a: assert property (r.state == ST_WR && MEM_GNT && last_x && last_y
      |=> !r.busy && r.int_flag && !MEM_REQ)
      else $error("final write did not end the operation");
   int_cause_a: assert property ($rose(r.int_flag) |-> $past(r.busy) && !r.busy)
      else $error("completion flag set without an operation ending");
   rop_copy_a: assert property (r.state == ST_CALC && rop_used && rop_code == ROP_S0 &&
      !r.skip |=> MEM_WDATA == $past(r.s0) && MEM_WE)
      else $error("copy raster code did not pass source zero");
   rop_xor_a: assert property (r.state == ST_CALC && rop_used && rop_code == ROP_XOR
      |=> MEM_WDATA == ($past(r.s0) ^ $past(r.s1)))
      else $error("xor raster code wrong");
   key_skip_a: assert property (r.state == ST_CALC && key && r.s0 == BG_COLOR
      |=> r.state != ST_WR)
      else $error("keyed pixel was written");
   expand_fg_a: assert property (r.state == ST_SRC && expand && r.have_word &&
      r.word[r.bit_idx] |=> r.s0 == $past(FG_COLOR) && !r.skip)
      else $error("set expansion bit did not give foreground");
   host_noread_a: assert property (MEM_REQ && !MEM_WE && host_src |-> r.state == ST_RD1)
      else $error("host source op read source zero from memory");
   solid_noread_a: assert property (MEM_REQ && solid |-> MEM_WE && MEM_WDATA == FG_COLOR)
      else $error("solid fill read memory or wrote wrong colour");
   busy_hold_a: assert property (r.busy && r.state != ST_IDLE ##1 r.state != ST_IDLE
      |-> r.busy)
      else $error("busy dropped mid operation");

endmodule // block_transfer_engine

`default_nettype wire

// [bte_pkg.sv]
// constants shared by the block transfer engine and its testbench
// assumes 16-bit rgb 5:6:5 pixels and a byte-wide register port
package bte_pkg;

   // register port offsets
   localparam logic [7:0] CTRL0_OFFSET  = 8'h90;
   localparam logic [7:0] CTRL1_OFFSET  = 8'h91;
   localparam logic [7:0] INTSRC_OFFSET = 8'h0C;

   // field positions
   localparam int CTRL0_BUSY_BIT    = 4;
   localparam int STATUS_BUSY_BIT   = 3;
   localparam int INTSRC_ENGINE_BIT = 1;
   localparam int ROP_LSB           = 4;

   // reset values
   localparam logic [7:0] CTRL1_RESET = 8'h00;

   // operation codes, low nibble of control one
   localparam logic [3:0] OP_HOST_ROP     = 4'h0;
   localparam logic [3:0] OP_MEM_ROP      = 4'h2;
   localparam logic [3:0] OP_HOST_KEY     = 4'h4;
   localparam logic [3:0] OP_MEM_KEY      = 4'h5;
   localparam logic [3:0] OP_PAT_ROP      = 4'h6;
   localparam logic [3:0] OP_PAT_KEY      = 4'h7;
   localparam logic [3:0] OP_HOST_EXP     = 4'h8;
   localparam logic [3:0] OP_HOST_EXP_KEY = 4'h9;
   localparam logic [3:0] OP_MEM_BLEND    = 4'hA;
   localparam logic [3:0] OP_HOST_BLEND   = 4'hB;
   localparam logic [3:0] OP_SOLID        = 4'hC;
   localparam logic [3:0] OP_MEM_EXP      = 4'hE;
   localparam logic [3:0] OP_MEM_EXP_KEY  = 4'hF;

   // raster codes with a fixed meaning
   localparam logic [3:0] ROP_ZERO = 4'h0;
   localparam logic [3:0] ROP_S1   = 4'hA;
   localparam logic [3:0] ROP_S0   = 4'hC;
   localparam logic [3:0] ROP_ONE  = 4'hF;
   localparam logic [3:0] ROP_XOR  = 4'h6;

   // widths and sizes
   localparam int         PIX_W           = 16;
   localparam int         MEM_PIX_BITS    = 16;
   localparam logic [5:0] ALPHA_FULL      = 6'h20;
   localparam int         FIFO_DEPTH_DEF  = 32;

endpackage

// [pixel_word_fifo.sv]
// word fifo with registered read data for host-written source words
// assumes a power-of-two depth and one clock shared with both sides
`timescale 1ns/10ps
`default_nettype none

module pixel_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   localparam int            AW         = $clog2(DEPTH);
   localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 count;
      logic [WIDTH-1:0]            out_data;
      logic                        out_valid;
   } fifo_s;

   fifo_s r;
   fifo_s next_r;
   logic  push;
   logic  load;

   always_comb begin
      next_r = r;
      in_ready = (r.count != FULL_COUNT);
      push = in_valid && in_ready;
      // refill the output register as soon as it empties or is taken
      load = (!r.out_valid || out_ready) && (r.count != '0);
      if (push) begin
         next_r.mem[r.wr] = in_data;
         next_r.wr = r.wr + 1'b1;
      end
      if (r.out_valid && out_ready) begin
         next_r.out_valid = 1'b0;
      end
      if (load) begin
         next_r.out_data = r.mem[r.rd];
         next_r.out_valid = 1'b1;
         next_r.rd = r.rd + 1'b1;
      end
      if (push && !load) begin
         next_r.count = r.count + 1'b1;
      end else if (!push && load) begin
         next_r.count = r.count - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign out_data = r.out_data;
   assign out_valid = r.out_valid;

   full_refuse_a: assert property (@(posedge clk) disable iff (rst)
      (r.count == FULL_COUNT) && !load |=> (r.count == FULL_COUNT))
      else $error("fifo lost its full state without a read");

endmodule // pixel_word_fifo

`default_nettype wire

// [pix_mem.sv]
// display memory model on the engine's memory port
// assumes one access in flight; words indexed by low address byte
`timescale 1ns/10ps
`default_nettype none
module pix_mem (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] wdata,
   output logic             gnt,
   output logic             rvalid,
   output logic      [15:0] rdata
);
   logic [15:0] mem [256];
   logic        hold;
   // idle data flips each cycle so a stale read never passes
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         gnt <= 1'b0;
         rvalid <= 1'b0;
         hold <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         hold <= slow & ~hold;
         gnt <= req & ~gnt & (~slow | hold);
         rvalid <= req & gnt & ~we;
         if (req & gnt & ~we)
            rdata <= mem[addr[7:0]];
         else
            rdata <= ~rdata;
         if (req & gnt & we)
            mem[addr[7:0]] <= wdata;
      end
   end
endmodule // pix_mem
`default_nettype wire

// [block_transfer_engine_tb.sv]
// self-checking bench for the block transfer engine
// assumes pix_mem as display memory, windows at 10h, 20h, 30h
`timescale 1ns/10ps
`default_nettype none
module block_transfer_engine_tb
   import bte_pkg::*;
;
   typedef struct {
      logic [3:0]  op;
      logic [3:0]  rop;
      logic [15:0] bg;
      logic [5:0]  al;
      logic [15:0] exp;
   } row_s;
   // 1234 means the destination pixel stays untouched
   row_s rows[12] = '{
      '{OP_HOST_ROP, ROP_XOR, 16'h0000, 6'h20, 16'h0FF0},
      '{OP_PAT_ROP, ROP_S0, 16'h0000, 6'h20, 16'hFF00},
      '{OP_HOST_KEY, ROP_ZERO, 16'hFF00, 6'h20, 16'h1234},
      '{OP_MEM_KEY, ROP_ZERO, 16'h0000, 6'h20, 16'hFF00},
      '{OP_PAT_KEY, ROP_ZERO, 16'hFF00, 6'h20, 16'h1234},
      '{OP_HOST_EXP, 4'h8, 16'h0000, 6'h20, 16'h5A5A},
      '{OP_HOST_EXP_KEY, 4'h0, 16'h00C3, 6'h20, 16'h1234},
      '{OP_MEM_EXP, 4'h0, 16'h00C3, 6'h20, 16'h00C3},
      '{OP_MEM_EXP_KEY, 4'hF, 16'h00C3, 6'h20, 16'h5A5A},
      '{OP_MEM_BLEND, ROP_ZERO, 16'h0000, 6'h00, 16'hF0F0},
      '{OP_HOST_BLEND, ROP_ZERO, 16'h0000, 6'h3F, 16'hFF00},
      '{OP_SOLID, ROP_ZERO, 16'h0000, 6'h20, 16'h5A5A}};
   logic        clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, int_en = 1'b1;
   logic        int_n, hvalid = 1'b0, hready, mreq, mwe, gnt, rv, slow = 1'b0;
   logic [7:0]  addr = 8'h00, wd = 8'h00, rd, status, b;
   logic [12:0] ww = 13'h0001;
   logic [15:0] bg = 16'h0000, hdata = 16'h0000, rdat, wdat, fg = 16'h5A5A;
   logic [5:0]  alpha = 6'h20;
   logic [23:0] maddr, s0b = 24'h000010;
   int          n_errors = 0, comparisons = 0, n;
   always #50 clk = ~clk;
   block_transfer_engine u_dut (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wd),
      .REG_WE(we), .REG_RE(re), .REG_RDATA(rd), .STATUS(status), .INT_EN(int_en),
      .INT_N(int_n), .S0_BASE(s0b), .S1_BASE(24'h000020), .DT_BASE(24'h000030),
      .STRIDE(13'h0040), .WIN_W(ww), .WIN_H(13'h0001), .FG_COLOR(fg),
      .BG_COLOR(bg), .ALPHA(alpha), .PATTERN_16(1'b0), .HOST_DATA(hdata),
      .HOST_VALID(hvalid), .HOST_READY(hready), .MEM_REQ(mreq), .MEM_WE(mwe),
      .MEM_ADDR(maddr), .MEM_WDATA(wdat), .MEM_GNT(gnt), .MEM_RVALID(rv),
      .MEM_RDATA(rdat));
   pix_mem u_mem (.clk(clk), .rst(rst), .slow(slow), .req(mreq), .we(mwe),
      .addr(maddr), .wdata(wdat), .gnt(gnt), .rvalid(rv), .rdata(rdat));
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // strobes drop one edge before the next access may raise them
   task automatic wr(logic [7:0] a, logic [7:0] d);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdreg(logic [7:0] a, output logic [7:0] d);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      @(posedge clk);
      d = rd;
   endtask
   task automatic start(logic [3:0] op, logic [3:0] rop);
      wr(CTRL1_OFFSET, {rop, op});
      wr(CTRL0_OFFSET, 8'h10);
   endtask
   task automatic finish_op();
      int k;
      k = 0;
      while (status[STATUS_BUSY_BIT] === 1'b1 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      @(negedge clk);
      chk("busy end", 16'h0000, 16'(status));
      chk("irq", 16'(!int_en), 16'(int_n));
      @(posedge clk);
      rdreg(INTSRC_OFFSET, b);
      chk("irq source", 16'h0002, 16'(b & 8'h02));
      wr(INTSRC_OFFSET, 8'h02);
   endtask
   task automatic run(logic [3:0] op, logic [3:0] rop, logic [15:0] k, logic [5:0] a);
      u_mem.mem[8'h10] = 16'hFF00;
      u_mem.mem[8'h20] = 16'hF0F0;
      u_mem.mem[8'h30] = 16'h1234;
      bg <= k;
      alpha <= a;
      if (op inside {OP_HOST_ROP, OP_HOST_KEY, OP_HOST_EXP, OP_HOST_EXP_KEY, OP_HOST_BLEND}) begin
         hdata <= 16'hFF00;
         hvalid <= 1'b1;
         @(posedge clk);
         hvalid <= 1'b0;
      end
      start(op, rop);
      finish_op();
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #2_000_000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdreg(CTRL1_OFFSET, b);
      chk("ctrl1 reset", 16'(CTRL1_RESET), 16'(b));
      chk("status reset", 16'h0000, 16'(status));
      rdreg(8'h55, b);
      chk("unmapped", 16'h0000, 16'(b));
      $display("reset test done");
      for (int r = 0; r < 16; r++) begin
         run(OP_MEM_ROP, 4'(r), 16'h0000, 6'h20);
         chk("rop", {{4{r[3]}}, {4{r[2]}}, {4{r[1]}}, {4{r[0]}}}, u_mem.mem[8'h30]);
      end
      $display("rop test done");
      foreach (rows[i]) begin
         int_en <= 1'(i % 2);
         run(rows[i].op, rows[i].rop, rows[i].bg, rows[i].al);
         chk("op row", rows[i].exp, u_mem.mem[8'h30]);
      end
      $display("table test done");
      ww <= 13'h0000;
      start(OP_SOLID, ROP_ZERO);
      chk("zero width", 16'h0000, 16'(status));
      ww <= 13'h0001;
      start(4'h3, ROP_ZERO);
      chk("reserved", 16'h0000, 16'(status));
      $display("refusal test done");
      // colour changed only while idle, the engine samples it during the fill
      fg <= 16'h0F0F;
      run(OP_SOLID, ROP_ZERO, 16'h0000, 6'h20);
      chk("solid colour", 16'h0F0F, u_mem.mem[8'h30]);
      fg <= 16'h5A5A;
      $display("colour test done");
      // fill the buffer while idle, then drain it against a stalling memory
      slow <= 1'b1;
      ww <= 13'h0021;
      n = 0;
      hvalid <= 1'b1;
      hdata <= 16'h0001;
      repeat (40) begin
         @(negedge clk);
         if (hready === 1'b1)
            n++;
         @(posedge clk);
         hdata <= 16'(n + 1);
      end
      hvalid <= 1'b0;
      chk("fifo depth", 16'(FIFO_DEPTH_DEF + 1), 16'(n));
      start(OP_HOST_ROP, ROP_S0);
      rdreg(CTRL0_OFFSET, b);
      chk("busy bit", 16'h0010, 16'(b & 8'h10));
      start(OP_SOLID, 4'h3);
      finish_op();
      rdreg(CTRL1_OFFSET, b);
      chk("ctrl1 kept", 16'h00C0, 16'(b));
      for (int i = 0; i < 33; i++)
         chk("stream", 16'(i + 1), u_mem.mem[8'h30 + i]);
      $display("buffer test done");
      report_and_stop();
   end
endmodule // block_transfer_engine_tb
`default_nettype wire
